// file: hdl/tick_map.svh
// Register offsets, field positions, reset values and prescale constants of the tick divider
`ifndef TICK_MAP_SVH
`define TICK_MAP_SVH

// Register offsets
`define TICK_CTRL_OFFSET 8'h07
`define TICK_STATUS_OFFSET 8'h10
`define TICK_CLEAR_OFFSET 8'h11
`define TICK_ENABLE_OFFSET 8'h12
`define TICK_STATE_OFFSET 8'h13

// Control register fields
`define TICK_DEC_BIT 7
`define TICK_RATE_MSB 6
`define TICK_RATE_LSB 4
`define TICK_MOD_MSB 3
`define TICK_MOD_LSB 0

// Reset values
`define TICK_CTRL_RESET 8'h00
`define TICK_IRQ_RESET 1'h0

// Binary prescale: factor is one shifted left by code plus this base
`define TICK_BIN_SHIFT_BASE 5'h09
`define TICK_BIN_OFF_CODE 3'h0

// Decimal prescale factors
`define TICK_DEC_F0 18'h003E8
`define TICK_DEC_F1 18'h007D0
`define TICK_DEC_F2 18'h01388
`define TICK_DEC_F3 18'h02710
`define TICK_DEC_F4 18'h04E20
`define TICK_DEC_F5 18'h0C350
`define TICK_DEC_F6 18'h186A0
`define TICK_DEC_F7 18'h30D40

`endif

// file: hdl/tick_pkg.sv
// Types shared by the tick divider modules
package tick_pkg;

   // Prescale factor width, large enough for the biggest decimal factor
   typedef logic [17:0] prescale_t;

   // Divider operating state, one-hot
   typedef enum logic [2:0] {
      TICK_OFF = 3'b001,
      TICK_COUNTING = 3'b010,
      TICK_FROZEN = 3'b100
   } tick_state_t;

endpackage : tick_pkg

// file: hdl/tick_prescale_table.sv
// Prescale factor lookup with a registered output
`timescale 1ns/1ns
`include "tick_map.svh"

module tick_prescale_table
   import tick_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Selection
   input wire logic decimal_prescale_select,
   input wire logic [2:0] prescale_rate_field,
   // Factor, zero means off
   output prescale_t factor_reg
);

   // Combinational factor
   prescale_t factor_next;

   // Factor decode for both families
   always_comb begin
      if (decimal_prescale_select) begin
         case (prescale_rate_field)
            3'h0: factor_next = `TICK_DEC_F0;
            3'h1: factor_next = `TICK_DEC_F1;
            3'h2: factor_next = `TICK_DEC_F2;
            3'h3: factor_next = `TICK_DEC_F3;
            3'h4: factor_next = `TICK_DEC_F4;
            3'h5: factor_next = `TICK_DEC_F5;
            3'h6: factor_next = `TICK_DEC_F6;
            default: factor_next = `TICK_DEC_F7;
         endcase
      end else if (prescale_rate_field == `TICK_BIN_OFF_CODE) begin
         // Binary code zero means the generator is off
         factor_next = 18'h00000;
      end else begin
         // Power of two from code plus base
         factor_next = 18'h00001 << (5'({2'h0, prescale_rate_field}) + `TICK_BIN_SHIFT_BASE);
      end
   end

   // Registered factor
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         factor_reg <= 18'h00000;
      end else begin
         factor_reg <= factor_next;
      end
   end

endmodule : tick_prescale_table

// file: hdl/periodic_tick_divider.sv
// Periodic tick divider with control register and interrupt logic
`timescale 1ns/1ns
`include "tick_map.svh"

module periodic_tick_divider
   import tick_pkg::*;
(
   // Oscillator clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Side controls from other registers
   input wire logic pseudo_stop_active,
   input wire logic pseudo_stop_run_enable,
   input wire logic debug_active,
   input wire logic debug_halt_counters,
   // Event outputs
   output logic periodic_tick,
   output logic irq
);

   // Address match helper
   function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
      addr_is = (addr == offset);
   endfunction : addr_is

   // Control register and its next value
   logic [7:0] tick_period_control_reg;
   logic [7:0] ctrl_next;
   // Interrupt status and enable
   logic status_reg;
   logic irq_enable_reg;
   // Counter chain
   prescale_t prescale_count_reg;
   logic [3:0] modulus_count_reg;
   // Factor from lookup, zero is off
   prescale_t factor;
   // Strobes
   logic ctrl_write;
   logic clear_write;
   // Terminal counts and run condition
   logic prescale_wrap;
   logic modulus_wrap;
   logic hold_request;
   tick_state_t state_reg;
   tick_state_t state_next;
   // Register output buffers
   logic tick_reg;
   logic irq_reg;
   logic [7:0] rdata_reg;

   assign ctrl_write = reg_write && addr_is(reg_addr, `TICK_CTRL_OFFSET);
   assign clear_write = reg_write && addr_is(reg_addr, `TICK_CLEAR_OFFSET);

   // new value takes effect
   // Lookup sees the new value in the write cycle
   assign ctrl_next = ctrl_write ? reg_wdata : tick_period_control_reg;

   // control reset value
   // Control register, any write accepted
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_period_control_reg <= `TICK_CTRL_RESET;
      end else begin
         tick_period_control_reg <= ctrl_next;
      end
   end

   tick_prescale_table u_table (
      .clock(clock),
      .reset_n(reset_n),
      .decimal_prescale_select(ctrl_next[`TICK_DEC_BIT]),
      .prescale_rate_field(ctrl_next[`TICK_RATE_MSB:`TICK_RATE_LSB]),
      .factor_reg(factor)
   );

   // debug halt
   // Freeze request from side controls
   assign hold_request = (pseudo_stop_active && !pseudo_stop_run_enable)
                       || (debug_active && debug_halt_counters);

   // Divider state decode
   always_comb begin
      if (factor == 18'h00000) begin
         // Generator off
         state_next = TICK_OFF;
      end else if (hold_request) begin
         // Frozen without reinit
         state_next = TICK_FROZEN;
      end else begin
         state_next = TICK_COUNTING;
      end
   end

   // State register, used only for readback
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= TICK_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prescale_wrap = (prescale_count_reg == factor - 18'h00001);
   assign modulus_wrap = (modulus_count_reg == tick_period_control_reg[`TICK_MOD_MSB:`TICK_MOD_LSB]);

   // counts on oscillator clock
   // Prescale counter
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prescale_count_reg <= 18'h00000;
      end else begin
         if (ctrl_write) begin
            prescale_count_reg <= 18'h00000;
         end else begin
            case (state_next)
               TICK_COUNTING: begin
                  // Wrap at factor minus one
                  if (prescale_wrap) begin
                     prescale_count_reg <= 18'h00000;
                  end else begin
                     prescale_count_reg <= prescale_count_reg + 18'h00001;
                  end
               end
               TICK_OFF: begin
                  // Held clear while off
                  prescale_count_reg <= 18'h00000;
               end
               TICK_FROZEN: begin
                  // Keep value
                  prescale_count_reg <= prescale_count_reg;
               end
               default: begin
                  prescale_count_reg <= 18'h00000;
               end
            endcase
         end
      end
   end

   // modulus stage
   // Modulus counter advanced on prescale wrap
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         modulus_count_reg <= 4'h0;
      end else begin
         if (ctrl_write || state_next == TICK_OFF) begin
            modulus_count_reg <= 4'h0;
         end else if (state_next == TICK_COUNTING && prescale_wrap) begin
            // Wrap when it reaches the modulus field
            if (modulus_wrap) begin
               modulus_count_reg <= 4'h0;
            end else begin
               modulus_count_reg <= modulus_count_reg + 4'h1;
            end
         end
      end
   end

   // tick at terminal count
   // One-cycle tick pulse
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_reg <= 1'h0;
      end else begin
         tick_reg <= !ctrl_write && state_next == TICK_COUNTING && prescale_wrap && modulus_wrap;
      end
   end

   // Sticky status, set wins over clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= 1'h0;
      end else if (tick_reg) begin
         // Tick event sets
         status_reg <= 1'h1;
      end else if (clear_write && reg_wdata[0]) begin
         // Write one clears
         status_reg <= 1'h0;
      end
   end

   // Interrupt enable register
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_enable_reg <= 1'h0;
      end else if (reg_write && addr_is(reg_addr, `TICK_ENABLE_OFFSET)) begin
         irq_enable_reg <= reg_wdata[0];
      end
   end

   // Level interrupt from enabled status
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         irq_reg <= `TICK_IRQ_RESET;
      end else begin
         irq_reg <= status_reg && irq_enable_reg;
      end
   end

   // Read data, one cycle after the strobe, zero elsewhere
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= 8'h00;
      end else if (reg_read) begin
         case (reg_addr)
            `TICK_CTRL_OFFSET: rdata_reg <= tick_period_control_reg;
            `TICK_STATUS_OFFSET: rdata_reg <= {7'h00, status_reg};
            `TICK_ENABLE_OFFSET: rdata_reg <= {7'h00, irq_enable_reg};
            `TICK_STATE_OFFSET: rdata_reg <= {5'h00, state_reg};
            // Clear register and unmapped read zero
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // Outputs straight from flops
   assign reg_rdata = rdata_reg;
   assign periodic_tick = tick_reg;
   assign irq = irq_reg;

endmodule : periodic_tick_divider

// file: tb/tick_props.sv
// Assertion checker on the tick divider ports
`timescale 1ns/1ns
module tick_props (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Side controls
   input wire logic pseudo_stop_active,
   input wire logic pseudo_stop_run_enable,
   input wire logic debug_active,
   input wire logic debug_halt_counters,
   // Events
   input wire logic periodic_tick,
   input wire logic irq
);
   // Control write and hold conditions
   wire ctl_wr = reg_write && reg_addr == 8'h07;
   wire ps_hold = pseudo_stop_active && !pseudo_stop_run_enable;
   wire db_hold = debug_active && debug_halt_counters;
   logic off_reg; // Generator off
   logic en_reg; // Interrupt enable copy
   logic [9:0] gap_reg; // Cycles since tick or write
   // Mirror off state and enable bit
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         off_reg <= 1'h1;
         en_reg <= 1'h0;
      end else begin
         if (ctl_wr) begin
            off_reg <= !reg_wdata[7] && reg_wdata[6:4] == 3'h0;
         end
         if (reg_write && reg_addr == 8'h12) begin
            en_reg <= reg_wdata[0];
         end
      end
   end
   // Saturating spacing counter, shortest period is 1000
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         gap_reg <= 10'h000;
      end else if (ctl_wr || periodic_tick) begin
         gap_reg <= 10'h000;
      end else if (gap_reg != 10'h3E7) begin
         gap_reg <= gap_reg + 10'h001;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   chk_tick_pulse:
      assert property (periodic_tick |=> !periodic_tick) else $error("tick too wide");
   chk_tick_spacing:
      assert property (periodic_tick |-> gap_reg == 10'h3E7) else $error("tick too early");
   chk_off_silent:
      assert property (off_reg |-> !periodic_tick) else $error("tick while off");
   chk_rdata_idle:
      assert property (!reg_read |=> reg_rdata == 8'h00) else $error("stray read data");
   chk_ctrl_readback:
      assert property (ctl_wr ##1 (reg_read && reg_addr == 8'h07) |=> reg_rdata == $past(reg_wdata, 2))
         else $error("control readback");
   chk_irq_masked:
      assert property (!$past(en_reg) && !en_reg |-> !irq) else $error("masked irq high");
   chk_pstop_freeze:
      assert property (ps_hold && $past(ps_hold) |-> !periodic_tick) else $error("tick in pseudo-stop");
   chk_debug_freeze:
      assert property (db_hold && $past(db_hold) |-> !periodic_tick) else $error("tick in debug halt");
   cover property (periodic_tick && en_reg);
   cover property (ps_hold ##1 ps_hold);
   cover property (db_hold ##1 db_hold);
endmodule : tick_props
bind periodic_tick_divider tick_props chk (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .pseudo_stop_active(pseudo_stop_active), .pseudo_stop_run_enable(pseudo_stop_run_enable),
   .debug_active(debug_active), .debug_halt_counters(debug_halt_counters),
   .periodic_tick(periodic_tick), .irq(irq));

// file: tb/periodic_tick_divider_tb.sv
// Self-checking bench for the periodic tick divider
`timescale 1ns/1ns
module periodic_tick_divider_tb;
   // Design ports
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
   logic reg_write = 1'h0, reg_read = 1'h0, periodic_tick, irq;
   logic ps_act = 1'h0, ps_en = 1'h0, dbg = 1'h0, halt = 1'h0;
   // Counts, random state, period cases {control, side inputs}
   int err_total = 0, checks = 0, cyc = 0, ticks = 0, t0;
   logic [31:0] lfsr = 32'hCD639BF4;
   int dec_f[8] = '{1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
   logic [11:0] tab[11] = '{12'h800, 12'h830, 12'h900, 12'hA00, 12'h100, 12'h210, 12'h808, 12'h80C,
      12'h803, 12'h802, 12'h801};
   periodic_tick_divider dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pseudo_stop_active(ps_act),
      .pseudo_stop_run_enable(ps_en), .debug_active(dbg), .debug_halt_counters(halt),
      .periodic_tick(periodic_tick), .irq(irq));
   // Clock, cycle limit and tick count
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      ticks += (periodic_tick === 1'h1);
      if (cyc == 80000) begin
         err_total++;
         end_sim();
      end
   end
   function automatic logic [31:0] next_rand(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : next_rand
   // Total divide from a control value
   function automatic int exp_period(logic [7:0] c);
      int f;
      f = c[7] ? dec_f[c[6:4]] : (c[6:4] == 3'h0 ? 0 : 1 << (c[6:4] + 9));
      return f * (c[3:0] + 1);
   endfunction : exp_period
   task automatic check(string name, logic [31:0] seen, logic [31:0] want);
      checks++;
      if (seen !== want) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", name, want, seen);
      end
   endtask : check
   // Strobes start where the caller stands, so a read may follow a write with no gap
   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clock);
      reg_write <= 1'h0;
   endtask : wr
   task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge clock);
      reg_read <= 1'h0;
      #1 d = reg_rdata;
   endtask : rd_reg
   // Write control mid-period, time two periods, side inputs held 200 cycles
   task automatic measure(logic [7:0] c, logic [3:0] s);
      int n;
      int want;
      want = exp_period(c) + (((s[3] && !s[2]) || (s[1] && s[0])) ? 200 : 0);
      lfsr = next_rand(lfsr);
      repeat (lfsr[8:0]) @(posedge clock);
      wr(8'h07, c);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         while (n < 250000) begin
            @(posedge clock);
            n++;
            if (n == 300 && k == 0) {ps_act, ps_en, dbg, halt} <= s;
            if (n == 500) {ps_act, ps_en, dbg, halt} <= 4'h0;
            #1;
            if (periodic_tick === 1'h1) break;
         end
         check("period", n, k ? exp_period(c) : want);
      end
   endtask : measure
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'h1;
      rd_reg(8'h07, rd);
      check("control", rd, 8'h00);
      rd_reg(8'h13, rd);
      check("state", rd, 8'h01);
      // Every mode and rate code with a random modulus
      for (int i = 0; i < 16; i++) begin
         lfsr = next_rand(lfsr);
         wr(8'h07, {i[3:0], lfsr[3:0]});
         rd_reg(8'h07, rd);
         check("control", rd, {i[3:0], lfsr[3:0]});
         rd_reg(8'h13, rd);
         check("state", rd, (i == 0) ? 8'h01 : 8'h02);
      end
      foreach (tab[j]) measure(tab[j][11:4], tab[j][3:0]);
      repeat (3) measure({7'h40, lfsr[0]}, 4'h0);
      // Interrupt raise, mask, clear
      wr(8'h12, 8'h01);
      measure(8'h80, 4'h0);
      repeat (3) @(posedge clock);
      #1 check("irq", irq, 1'h1);
      rd_reg(8'h10, rd);
      check("status", rd, 8'h01);
      wr(8'h12, 8'h00);
      repeat (2) @(posedge clock);
      #1 check("irq", irq, 1'h0);
      wr(8'h11, 8'h01);
      rd_reg(8'h10, rd);
      check("status", rd, 8'h00);
      rd_reg(8'h20, rd);
      check("unmapped", rd, 8'h00);
      // Off codes stay silent
      foreach (tab[j]) begin
         wr(8'h07, j[0] ? 8'h00 : 8'h0F);
         t0 = ticks;
         repeat (1100) @(posedge clock);
         check("ticks", ticks - t0, 0);
         if (j == 1) break;
      end
      end_sim();
   end
endmodule : periodic_tick_divider_tb
